/* File: src/alu_add_shift_core.sv */
/*
  Execution datapath for the pointer add, mask, sum, sum with carry,
  sign shift and bit clear operations, with accumulator, flags and
  two pointer pairs. Assumes the decoder presents decoded fields and
  the file register's current value on the core clock.
*/
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/10ps
// Notes on behaviour
// (RULE1) Pointer add: signed 6-bit offset, flags kept
// (RULE2) Pointer sum wraps modulo 16 bits
// (RULE3) Literal mask into accumulator, null flag only
// (RULE4) Literal sum into accumulator, three flags
// (RULE5) Destination bit: 0 accumulator, 1 file
// (RULE6) Register mask to destination, null flag only
// (RULE7) Register sum to destination, three flags
// (RULE8) Register sum plus carry, three flags
// (RULE9) Sign shift right, old bit0 to carry
// (RULE10) Bit clear in file, flags untouched
// (RULE11) Indirect target with pointer MSB: extra cycle
// (RULE12) Null on zero, carry bit7, nibble bit3
module alu_add_shift_core (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // Register port
  input wire logic [alu_pkg::RADDR_W-1:0] REG_ADDR,
  input wire logic [alu_pkg::DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [alu_pkg::DATA_W-1:0] REG_RDATA,
  // Decoded operation
  input wire logic OP_VALID,
  input wire alu_pkg::op_e OP_CODE,
  input wire logic [alu_pkg::DATA_W-1:0] OP_LIT,
  input wire logic [alu_pkg::FADDR_W-1:0] OP_FADDR,
  input wire logic OP_DEST,
  input wire logic [alu_pkg::BIT_W-1:0] OP_BIT,
  input wire logic OP_PTR_SEL,
  input wire logic [alu_pkg::DATA_W-1:0] FILE_RDATA,
  output logic OP_READY,
  output logic OP_DONE,
  // File register write back
  output logic FILE_WE,
  output logic [alu_pkg::FADDR_W-1:0] FILE_WADDR,
  output logic [alu_pkg::DATA_W-1:0] FILE_WDATA
);
  import alu_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] accum;
    logic carry;
    logic nibble_half_flag;
    logic null_flag;
    logic [PTR_W-1:0] pointer_pair0;
    logic [PTR_W-1:0] pointer_pair1;
    logic [DATA_W-1:0] rdata;
    logic stall;
    logic ready;
    logic done;
    logic file_we;
    logic [FADDR_W-1:0] file_waddr;
    logic [DATA_W-1:0] file_wdata;
    op_e h_op;
    logic [DATA_W-1:0] h_lit;
    logic [FADDR_W-1:0] h_faddr;
    logic h_dest;
    logic [BIT_W-1:0] h_bit;
    logic h_ptr_sel;
    logic [DATA_W-1:0] h_fdata;
  } state_s;

  state_s st;
  state_s next_st;

  alu_calc_if cif ();

  alu_calc u_calc (
    .cif(cif.calc)
  );

  alu_ptr_add u_ptr (
    .pif(cif.ptr)
  );

  // Operations that read a file register
  function automatic logic uses_file(input op_e op);
    case (op)
      OP_REG_MASK, OP_REG_SUM, OP_REG_SUM_C, OP_SHIFT, OP_BIT_CLR:
        uses_file = 1'b1;
      default:
        uses_file = 1'b0;
    endcase
  endfunction

  // Operations whose sum updates carry and nibble flags
  function automatic logic sets_sum_flags(input op_e op);
    case (op)
      OP_LIT_SUM, OP_REG_SUM, OP_REG_SUM_C:
        sets_sum_flags = 1'b1;
      default:
        sets_sum_flags = 1'b0;
    endcase
  endfunction

  logic penalty;
  logic accept;
  logic exec;
  op_e x_op;
  logic [DATA_W-1:0] x_lit;
  logic [FADDR_W-1:0] x_faddr;
  logic x_dest;
  logic [BIT_W-1:0] x_bit;
  logic x_ptr_sel;
  logic [DATA_W-1:0] x_fdata;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.file_we = 1'b0;
    // Indirect access through a pointer with MSB set costs a cycle
    penalty = uses_file(OP_CODE) &&
      ((OP_FADDR == INDIRECT_TARGET0 && st.pointer_pair0[PTR_W-1]) ||
       (OP_FADDR == INDIRECT_TARGET1 && st.pointer_pair1[PTR_W-1])); // RULE11
    accept = OP_VALID && !st.stall;
    exec = (accept && !penalty) || st.stall; // RULE11
    x_op = st.stall ? st.h_op : OP_CODE;
    x_lit = st.stall ? st.h_lit : OP_LIT;
    x_faddr = st.stall ? st.h_faddr : OP_FADDR;
    x_dest = st.stall ? st.h_dest : OP_DEST;
    x_bit = st.stall ? st.h_bit : OP_BIT;
    x_ptr_sel = st.stall ? st.h_ptr_sel : OP_PTR_SEL;
    x_fdata = st.stall ? st.h_fdata : FILE_RDATA;
    if (accept) begin
      next_st.h_op = OP_CODE;
      next_st.h_lit = OP_LIT;
      next_st.h_faddr = OP_FADDR;
      next_st.h_dest = OP_DEST;
      next_st.h_bit = OP_BIT;
      next_st.h_ptr_sel = OP_PTR_SEL;
      next_st.h_fdata = FILE_RDATA;
    end
    next_st.stall = accept && penalty; // RULE11
    next_st.ready = !(accept && penalty); // RULE11

    cif.op = x_op;
    cif.a = st.accum;
    cif.b = uses_file(x_op) ? x_fdata : x_lit;
    cif.cin = (x_op == OP_REG_SUM_C) ? st.carry : 1'b0; // RULE8
    cif.bidx = x_bit;
    cif.ptr_in = x_ptr_sel ? st.pointer_pair1 : st.pointer_pair0;
    cif.ofs = x_lit[OFS_W-1:0]; // RULE1

    // Register port writes; an executing operation overrides them
    if (REG_WR) begin
      case (REG_ADDR)
        REG_ACCUM: next_st.accum = REG_WDATA;
        REG_FLAGS: begin
          next_st.carry = REG_WDATA[FLAG_CARRY];
          next_st.nibble_half_flag = REG_WDATA[FLAG_NIBBLE];
          next_st.null_flag = REG_WDATA[FLAG_NULL];
        end
        REG_PTR0_LO: next_st.pointer_pair0[DATA_W-1:0] = REG_WDATA;
        REG_PTR0_HI: next_st.pointer_pair0[PTR_W-1:DATA_W] = REG_WDATA;
        REG_PTR1_LO: next_st.pointer_pair1[DATA_W-1:0] = REG_WDATA;
        REG_PTR1_HI: next_st.pointer_pair1[PTR_W-1:DATA_W] = REG_WDATA;
        default: begin
        end
      endcase
    end

    if (exec && x_op != OP_NONE) begin
      next_st.done = 1'b1;
      case (x_op)
        OP_PTR_ADD: begin
          if (x_ptr_sel) begin
            next_st.pointer_pair1 = cif.ptr_out; // RULE2
          end else begin
            next_st.pointer_pair0 = cif.ptr_out; // RULE2
          end
        end
        OP_LIT_MASK, OP_LIT_SUM: begin
          next_st.accum = cif.result; // RULE3 RULE4
        end
        OP_BIT_CLR: begin
          next_st.file_we = 1'b1; // RULE10
          next_st.file_waddr = x_faddr;
          next_st.file_wdata = cif.result;
        end
        default: begin
          if (x_dest) begin
            next_st.file_we = 1'b1; // RULE5
            next_st.file_waddr = x_faddr;
            next_st.file_wdata = cif.result;
          end else begin
            next_st.accum = cif.result; // RULE5 RULE6 RULE7
          end
        end
      endcase
      if (x_op != OP_PTR_ADD && x_op != OP_BIT_CLR) begin
        next_st.null_flag = (cif.result == ACCUM_RST); // RULE12
      end
      if (sets_sum_flags(x_op)) begin
        next_st.carry = cif.c_out; // RULE12
        next_st.nibble_half_flag = cif.dc_out; // RULE12
      end
      if (x_op == OP_SHIFT) begin
        next_st.carry = cif.c_out; // RULE9
      end
    end

    // Read data shows the state before this cycle's update
    next_st.rdata = '0;
    if (REG_RD) begin
      case (REG_ADDR)
        REG_ACCUM: next_st.rdata = st.accum;
        REG_FLAGS: begin
          next_st.rdata[FLAG_CARRY] = st.carry;
          next_st.rdata[FLAG_NIBBLE] = st.nibble_half_flag;
          next_st.rdata[FLAG_NULL] = st.null_flag;
        end
        REG_PTR0_LO: next_st.rdata = st.pointer_pair0[DATA_W-1:0];
        REG_PTR0_HI: next_st.rdata = st.pointer_pair0[PTR_W-1:DATA_W];
        REG_PTR1_LO: next_st.rdata = st.pointer_pair1[DATA_W-1:0];
        REG_PTR1_HI: next_st.rdata = st.pointer_pair1[PTR_W-1:DATA_W];
        default: next_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st <= '0;
      st.accum <= ACCUM_RST;
      st.pointer_pair0 <= PTR_RST;
      st.pointer_pair1 <= PTR_RST;
      st.h_op <= OP_NONE;
      st.ready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign REG_RDATA = st.rdata;
  assign OP_READY = st.ready;
  assign OP_DONE = st.done;
  assign FILE_WE = st.file_we;
  assign FILE_WADDR = st.file_waddr;
  assign FILE_WDATA = st.file_wdata;

  AST_PTR_FLAGS: assert property ( // RULE1
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (st.done && st.h_op == OP_PTR_ADD && !$past(REG_WR)) |->
      $stable(st.carry) && $stable(st.nibble_half_flag) &&
      $stable(st.null_flag) && $stable(st.accum))
    else $error("pointer add changed flags or accumulator");

  AST_PTR_WRAP: assert property ( // RULE2
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (st.done && st.h_op == OP_PTR_ADD && !st.h_ptr_sel) |->
      st.pointer_pair0 == PTR_W'($past(st.pointer_pair0) +
      {{(PTR_W-OFS_W){st.h_lit[OFS_W-1]}}, st.h_lit[OFS_W-1:0]}))
    else $error("pointer pair 0 offset sum wrong");

  AST_LIT_MASK: assert property ( // RULE3
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (st.done && st.h_op == OP_LIT_MASK) |->
      st.accum == ($past(st.accum) & st.h_lit) &&
      st.null_flag == (st.accum == ACCUM_RST))
    else $error("literal mask result wrong");

  AST_LIT_SUM: assert property ( // RULE4
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (st.done && st.h_op == OP_LIT_SUM) |->
      {st.carry, st.accum} == ({1'b0, $past(st.accum)} +
      {1'b0, st.h_lit}))
    else $error("literal sum or carry wrong");

  AST_DEST_FILE: assert property ( // RULE5
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (st.done && st.h_dest && uses_file(st.h_op) && !$past(REG_WR)) |->
      FILE_WE && FILE_WADDR == st.h_faddr && $stable(st.accum))
    else $error("file destination not honoured");

  AST_SUM_CARRY: assert property ( // RULE8
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (st.done && st.h_op == OP_REG_SUM_C && st.h_dest) |->
      {st.carry, FILE_WDATA} == ({1'b0, $past(st.accum)} +
      {1'b0, st.h_fdata} + {8'h00, $past(st.carry)}))
    else $error("sum with carry wrong");

  AST_SHIFT: assert property ( // RULE9
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (st.done && st.h_op == OP_SHIFT && !st.h_dest) |->
      st.carry == st.h_fdata[0] && st.accum[DATA_W-1] ==
      st.h_fdata[DATA_W-1] && st.accum[DATA_W-2:0] ==
      st.h_fdata[DATA_W-1:1])
    else $error("sign shift wrong");

  AST_BIT_CLR: assert property ( // RULE10
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (st.done && st.h_op == OP_BIT_CLR) |->
      FILE_WE && FILE_WDATA[st.h_bit] == 1'b0 &&
      (FILE_WDATA | (8'h01 << st.h_bit)) ==
      (st.h_fdata | (8'h01 << st.h_bit)))
    else $error("bit clear wrong");

  AST_INDIRECT_STALL: assert property ( // RULE11
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (accept && penalty && OP_CODE != OP_NONE) |=>
      !OP_READY && !OP_DONE ##1 OP_READY && OP_DONE)
    else $error("indirect penalty cycle wrong");

  AST_NULL_FLAG: assert property ( // RULE12
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (st.done && st.h_op == OP_REG_SUM && !st.h_dest) |->
      st.null_flag == (st.accum == ACCUM_RST) &&
      st.nibble_half_flag == (({4'h0, $past(st.accum[3:0])} +
      {4'h0, st.h_fdata[3:0]}) > NIBBLE_MAX))
    else $error("null or nibble flag wrong");

endmodule // alu_add_shift_core

/* File: src/alu_calc.sv */
/*
  Combinational byte unit: masks, sums, sign shift and bit clear.
  Assumes the caller picks which flags to keep.
*/
`timescale 1ns/10ps
module alu_calc (
  alu_calc_if.calc cif
);
  import alu_pkg::*;

  logic [DATA_W:0] sum;
  logic [DATA_W-1:0] low;

  always_comb begin
    sum = {1'b0, cif.a} + {1'b0, cif.b} + {{DATA_W{1'b0}}, cif.cin};
    low = {4'h0, cif.a[3:0]} + {4'h0, cif.b[3:0]} +
          {{(DATA_W-1){1'b0}}, cif.cin};
    cif.result = sum[DATA_W-1:0];
    cif.c_out = sum[DATA_W];
    cif.dc_out = low > NIBBLE_MAX;
    case (cif.op)
      OP_LIT_MASK, OP_REG_MASK: begin
        cif.result = cif.a & cif.b;
      end
      OP_SHIFT: begin
        cif.result = {cif.b[DATA_W-1], cif.b[DATA_W-1:1]};
        cif.c_out = cif.b[0];
      end
      OP_BIT_CLR: begin
        cif.result = cif.b & ~(8'h01 << cif.bidx);
      end
      default: begin
      end
    endcase
  end
endmodule // alu_calc

/* File: src/alu_calc_if.sv */
/*
  Operand and result bundle between the datapath top and its two
  combinational helpers. Assumes all users sit on the core clock.
*/
`timescale 1ns/10ps
interface alu_calc_if;
  import alu_pkg::*;
  op_e op;
  logic [DATA_W-1:0] a;
  logic [DATA_W-1:0] b;
  logic cin;
  logic [BIT_W-1:0] bidx;
  logic [DATA_W-1:0] result;
  logic c_out;
  logic dc_out;
  logic [PTR_W-1:0] ptr_in;
  logic [OFS_W-1:0] ofs;
  logic [PTR_W-1:0] ptr_out;

  modport calc (input op, a, b, cin, bidx,
                output result, c_out, dc_out);
  modport ptr (input ptr_in, ofs, output ptr_out);
  modport user (output op, a, b, cin, bidx, ptr_in, ofs,
                input result, c_out, dc_out, ptr_out);
endinterface

/* File: src/alu_pkg.sv */
/*
  Shared constants and types for the add/mask/shift execution datapath.
  Assumes one core clock domain; widths follow the 8-bit core.
*/
package alu_pkg;

  localparam int DATA_W = 8;
  localparam int PTR_W = 16;
  localparam int FADDR_W = 7;
  localparam int BIT_W = 3;
  localparam int OFS_W = 6;
  localparam int RADDR_W = 3;

  // Register port map
  localparam logic [RADDR_W-1:0] REG_ACCUM = 3'h0;
  localparam logic [RADDR_W-1:0] REG_FLAGS = 3'h1;
  localparam logic [RADDR_W-1:0] REG_PTR0_LO = 3'h2;
  localparam logic [RADDR_W-1:0] REG_PTR0_HI = 3'h3;
  localparam logic [RADDR_W-1:0] REG_PTR1_LO = 3'h4;
  localparam logic [RADDR_W-1:0] REG_PTR1_HI = 3'h5;

  // Flag register bit positions
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_NIBBLE = 1;
  localparam int FLAG_NULL = 2;

  // File addresses that reach memory through a pointer pair
  localparam logic [FADDR_W-1:0] INDIRECT_TARGET0 = 7'h00;
  localparam logic [FADDR_W-1:0] INDIRECT_TARGET1 = 7'h01;

  localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
  localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] NIBBLE_MAX = 8'h0f;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_PTR_ADD,
    OP_LIT_MASK,
    OP_LIT_SUM,
    OP_REG_MASK,
    OP_REG_SUM,
    OP_REG_SUM_C,
    OP_SHIFT,
    OP_BIT_CLR
  } op_e;

endpackage

/* File: src/alu_ptr_add.sv */
/*
  Combinational pointer pair offset adder.
  Assumes a signed offset; the sum wraps within the pointer width.
*/
`timescale 1ns/10ps
module alu_ptr_add (
  alu_calc_if.ptr pif
);
  import alu_pkg::*;

  // Sign extend, then drop the carry so the pointer wraps
  assign pif.ptr_out = pif.ptr_in +
    {{(PTR_W-OFS_W){pif.ofs[OFS_W-1]}}, pif.ofs};
endmodule // alu_ptr_add

/* File: tb/alu_add_and_shift_ops_tb_top.sv */
/*
  Directed bench for the add/mask/shift datapath.
  Assumes the file memory model as operand source and write sink.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; \
  if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %h got %h", nm, (e), (g)); end end
module alu_add_and_shift_ops_tb_top;
  import alu_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic op_valid = 1'b0;
  op_e op_code = OP_NONE;
  logic [7:0] op_lit = 8'h00;
  logic [6:0] op_faddr = 7'h00;
  logic op_dest = 1'b0;
  logic [2:0] op_bit = 3'h0;
  logic op_ptr_sel = 1'b0;
  logic [7:0] file_rdata;
  logic op_ready;
  logic op_done;
  logic file_we;
  logic [6:0] file_waddr;
  logic [7:0] file_wdata;
  logic load_en = 1'b0;
  logic [6:0] load_addr = 7'h00;
  logic [7:0] load_data = 8'h00;
  logic [15:0] seen;
  int error_cnt = 0;
  int n_compared = 0;

  alu_add_shift_core u_dut (
    .CORE_CLK(clk), .SYS_RST(rst), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .OP_VALID(op_valid), .OP_CODE(op_code),
    .OP_LIT(op_lit), .OP_FADDR(op_faddr), .OP_DEST(op_dest),
    .OP_BIT(op_bit), .OP_PTR_SEL(op_ptr_sel), .FILE_RDATA(file_rdata),
    .OP_READY(op_ready), .OP_DONE(op_done), .FILE_WE(file_we),
    .FILE_WADDR(file_waddr), .FILE_WDATA(file_wdata)
  );

  file_mem_model u_mem (
    .CORE_CLK(clk), .rd_addr(op_faddr), .rd_data(file_rdata),
    .we(file_we), .waddr(file_waddr), .wdata(file_wdata),
    .load_en(load_en), .load_addr(load_addr), .load_data(load_data)
  );

  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    `CHK("reg_rdata", e, reg_rdata)
  endtask

  task automatic ld(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    load_en <= 1'b1;
    load_addr <= a;
    load_data <= d;
    @(posedge clk);
    load_en <= 1'b0;
  endtask

  // Issue one op, wait for completion and capture the write back
  task automatic op(input op_e c, input logic [7:0] l, input logic [6:0] f,
                    input logic d, input logic [2:0] b, input logic s,
                    input int lat);
    int n;
    logic rdy1;
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_lit <= l;
    op_faddr <= f;
    op_dest <= d;
    op_bit <= b;
    op_ptr_sel <= s;
    @(posedge clk);
    op_valid <= 1'b0;
    rdy1 = 1'b0;
    for (n = 1; n <= 4; n++) begin
      @(negedge clk);
      if (n == 1)
        rdy1 = op_ready;
      if (op_done === 1'b1)
        break;
    end
    seen = {file_we, file_waddr, file_wdata};
    `CHK("op_latency", lat, n)
    `CHK("op_ready", (lat != 2), rdy1)
    // A latency of 5 means no completion is expected
    if (n > 4 && lat < 5) begin
      error_cnt++;
      conclude();
    end
  endtask

  task automatic wb(input logic [15:0] e);
    `CHK("file_wb", e, seen)
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++)
      rd(3'(i), 8'h00);
    wr(3'h6, 8'h5a);
    rd(3'h6, 8'h00);
    // Mask with literal must keep carry and nibble flags
    wr(REG_ACCUM, 8'h3c);
    wr(REG_FLAGS, 8'h03);
    op(OP_LIT_MASK, 8'hc3, 7'h00, 1'b0, 3'h0, 1'b0, 1);
    rd(REG_ACCUM, 8'h00);
    rd(REG_FLAGS, 8'h07);
    // Literal sums in sequence with reads between, each sees the last result
    wr(REG_ACCUM, 8'hf8);
    wr(REG_FLAGS, 8'h00);
    op(OP_LIT_SUM, 8'h08, 7'h00, 1'b0, 3'h0, 1'b0, 1);
    rd(REG_ACCUM, 8'h00);
    rd(REG_FLAGS, 8'h07);
    op(OP_LIT_SUM, 8'h0f, 7'h00, 1'b0, 3'h0, 1'b0, 1);
    rd(REG_FLAGS, 8'h00);
    op(OP_LIT_SUM, 8'h01, 7'h00, 1'b0, 3'h0, 1'b0, 1);
    rd(REG_ACCUM, 8'h10);
    rd(REG_FLAGS, 8'h02);
    // Register mask into the file register
    wr(REG_ACCUM, 8'hf0);
    wr(REG_FLAGS, 8'h05);
    ld(7'h05, 8'h3c);
    op(OP_REG_MASK, 8'h00, 7'h05, 1'b1, 3'h0, 1'b0, 1);
    wb({1'b1, 7'h05, 8'h30});
    rd(REG_ACCUM, 8'hf0);
    rd(REG_FLAGS, 8'h01);
    // Register sum into the accumulator at the top address
    ld(7'h7f, 8'h80);
    wr(REG_ACCUM, 8'h80);
    op(OP_REG_SUM, 8'h00, 7'h7f, 1'b0, 3'h0, 1'b0, 1);
    `CHK("file_we", 1'b0, seen[15])
    rd(REG_ACCUM, 8'h00);
    rd(REG_FLAGS, 8'h05);
    // Sum with the carry left by the previous op
    wr(REG_ACCUM, 8'h0f);
    op(OP_REG_SUM_C, 8'h00, 7'h7f, 1'b1, 3'h0, 1'b0, 1);
    wb({1'b1, 7'h7f, 8'h90});
    rd(REG_FLAGS, 8'h02);
    // Sign shift keeps bit 7, old bit 0 to carry
    ld(7'h09, 8'h81);
    op(OP_SHIFT, 8'h00, 7'h09, 1'b0, 3'h0, 1'b0, 1);
    rd(REG_ACCUM, 8'hc0);
    rd(REG_FLAGS, 8'h03);
    // Bit clear at every position, destination bit ignored
    wr(REG_FLAGS, 8'h05);
    for (int b = 0; b < 8; b++) begin
      ld(7'h0a, 8'hff);
      op(OP_BIT_CLR, 8'h00, 7'h0a, 1'b0, 3'(b), 1'b0, 1);
      wb({1'b1, 7'h0a, ~(8'h01 << b)});
    end
    rd(REG_FLAGS, 8'h05);
    // Pointer adds across both ends of the span
    wr(REG_PTR0_LO, 8'hfe);
    wr(REG_PTR0_HI, 8'hff);
    op(OP_PTR_ADD, 8'h05, 7'h00, 1'b0, 3'h0, 1'b0, 1);
    rd(REG_PTR0_LO, 8'h03);
    rd(REG_PTR0_HI, 8'h00);
    wr(REG_PTR1_LO, 8'h10);
    wr(REG_PTR1_HI, 8'h00);
    op(OP_PTR_ADD, 8'ha0, 7'h00, 1'b0, 3'h0, 1'b1, 1);
    rd(REG_PTR1_LO, 8'hf0);
    rd(REG_PTR1_HI, 8'hff);
    rd(REG_FLAGS, 8'h05);
    // Indirect target: penalty only with pointer bit 15 set
    ld(7'h01, 8'h11);
    ld(7'h00, 8'h22);
    wr(REG_ACCUM, 8'h01);
    op(OP_REG_SUM, 8'h00, 7'h01, 1'b0, 3'h0, 1'b0, 2);
    rd(REG_ACCUM, 8'h12);
    op(OP_REG_SUM, 8'h00, 7'h00, 1'b0, 3'h0, 1'b0, 1);
    rd(REG_ACCUM, 8'h34);
    // Empty slot is taken but never completes or writes back
    op(OP_NONE, 8'hff, 7'h01, 1'b1, 3'h0, 1'b0, 5);
    `CHK("file_we", 1'b0, seen[15])
    rd(REG_ACCUM, 8'h34);
    conclude();
  end
endmodule // alu_add_and_shift_ops_tb_top

/* File: tb/file_mem_model.sv */
/*
  Data memory model at the decoder side: serves the file operand and
  takes write back. Assumes one core clock and bench preloading.
*/
`timescale 1ns/10ps
module file_mem_model (
  // Clock
  input wire logic CORE_CLK,
  // Operand read and write back
  input wire logic [6:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic we,
  input wire logic [6:0] waddr,
  input wire logic [7:0] wdata,
  // Preload from bench
  input wire logic load_en,
  input wire logic [6:0] load_addr,
  input wire logic [7:0] load_data
);
  logic [7:0] mem [128];
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // Forward a write that lands at the same edge the next op is taken
  assign rd_data = (we && waddr == rd_addr) ? wdata : mem[rd_addr];
  always @(posedge CORE_CLK) begin
    if (we)
      mem[waddr] <= wdata;
    if (load_en)
      mem[load_addr] <= load_data;
  end
endmodule // file_mem_model
